// ==== usbt_pkg.sv ====
package usbt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFS_IRQ_DISABLE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RX_HOLDING = 8'h18;
  localparam logic [7:0] OFS_TX_HOLDING = 8'h1C;
  localparam logic [7:0] OFS_BAUD = 8'h20;
  localparam logic [7:0] OFS_IDLE_LIMIT = 8'h24;
  // status and mask bit positions
  localparam int ST_RX_READY = 0;
  localparam int ST_TX_FREE = 1;
  localparam int ST_BREAK = 2;
  localparam int ST_RX_DONE = 3;
  localparam int ST_TX_DONE = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAMING = 6;
  localparam int ST_PARITY = 7;
  localparam int ST_TIMEOUT = 8;
  localparam int ST_DRAINED = 9;
  localparam int ST_WIDTH = 10;
  // command bits
  localparam int CMD_RX_ON = 4;
  localparam int CMD_RX_OFF = 5;
  localparam int CMD_TX_ON = 6;
  localparam int CMD_TX_OFF = 7;
  localparam int CMD_RST_STATUS = 8;
  localparam int CMD_BREAK_START = 9;
  localparam int CMD_START_TIMEOUT = 11;
  // mode fields
  localparam int MD_CLKSRC_LSB = 4;
  localparam int MD_CHRL_LSB = 6;
  localparam int MD_SYNC = 8;
  localparam int MD_PAR_LSB = 9;
  localparam int MD_MODE9 = 17;
  localparam int MD_WIDTH = 18;
  // parity encodings
  localparam logic [2:0] PAR_EVEN = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [1:0] PAR_NONE_HI = 2'h2;
  localparam logic [1:0] PAR_MULTI_HI = 2'h3;
  // widths, reset values, timing
  localparam int CHAR_W = 9;
  localparam int DIV_W = 16;
  localparam int LIMIT_W = 8;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
  localparam logic [LIMIT_W-1:0] LIMIT_RESET = 8'h00;
  localparam logic [MD_WIDTH-1:0] MODE_RESET = 18'h00000;
  localparam logic [ST_WIDTH-1:0] MASK_RESET = 10'h000;
  localparam logic [DIV_W-1:0] DIV_STOP = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_BYPASS = 16'h0001;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [1:0] CLKSRC_MASTER = 2'h0;
  // time-out sequencer states
  typedef enum logic [2:0] {
    TO_IDLE = 3'b001,
    TO_ARMED = 3'b010,
    TO_RUN = 3'b100
  } usbt_tostate_t;
endpackage : usbt_pkg

// ==== usbt_status_core.sv ====
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module usbt_status_core
  import usbt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // receiver side
  input wire logic rxCharDone,
  input wire logic [CHAR_W-1:0] rxCharIn,
  input wire logic rxStopLow,
  input wire logic rxParityBit,
  input wire logic rxBreakEvt,
  // transmitter side
  input wire logic txShiftTake,
  input wire logic txShiftBusy,
  input wire logic txBreakTake,
  input wire logic txBreakActive,
  output logic txHoldValid,
  output logic [CHAR_W-1:0] txHoldChar,
  output logic txBreakPending,
  // block transfer controller
  input wire logic rxEndXfer,
  input wire logic txEndXfer,
  // bit clocks
  input wire logic extClkEn,
  output logic sampleTick,
  output logic bitTick,
  // channel control
  output logic rxOn,
  output logic txOn,
  output logic [MD_WIDTH-1:0] modeBits,
  output logic chanIrq
);

  // register state
  logic [31:0] rdData_reg, rdData_next;
  logic rxOn_reg, rxOn_next, txOn_reg, txOn_next;
  logic [MD_WIDTH-1:0] mode_reg, mode_next;
  logic [ST_WIDTH-1:0] mask_reg, mask_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [LIMIT_W-1:0] limit_reg, limit_next;
  logic [CHAR_W-1:0] rxChar_reg, rxChar_next, txChar_reg, txChar_next;
  logic holdFull_reg, holdFull_next, brkPend_reg, brkPend_next;
  logic rxReady_reg, rxReady_next, breakSeen_reg, breakSeen_next;
  logic overrun_reg, overrun_next, framing_reg, framing_next;
  logic parErr_reg, parErr_next, timeout_reg, timeout_next;
  logic irq_reg, irq_next;
  // baud state
  logic [DIV_W-1:0] divCnt_reg, divCnt_next;
  logic [3:0] subCnt_reg, subCnt_next;
  logic sample_reg, sample_next, bit_reg, bit_next;
  // time-out state
  usbt_tostate_t toState_reg, toState_next;
  logic [LIMIT_W-1:0] toCnt_reg, toCnt_next;
  logic [1:0] quarter_reg, quarter_next;
  // decoded strobes and status
  logic wrCmd, wrLimit, rdRx, startTo, rstStatus, syncExt, parBad, toExpire;
  logic txFreeBit, drainedBit;
  logic [ST_WIDTH-1:0] statusWord;

  // mask for the configured character length
  function automatic logic [CHAR_W-1:0] charMask(input logic [MD_WIDTH-1:0] md);
    logic [CHAR_W-1:0] m;
    m = 9'h01F;
    if (md[MD_MODE9])
      m = 9'h1FF;
    else
      m = 9'h01F | (9'h0E0 >> (2'h3 - md[MD_CHRL_LSB +: 2]));
    return m;
  endfunction : charMask

  // register address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // strobe decode
  always_comb
  begin
    wrCmd = regWr && hit(regAddr, OFS_COMMAND);
    wrLimit = regWr && hit(regAddr, OFS_IDLE_LIMIT);
    rdRx = regRd && hit(regAddr, OFS_RX_HOLDING);
    rstStatus = wrCmd && regWrData[CMD_RST_STATUS];
    startTo = (wrCmd && regWrData[CMD_START_TIMEOUT]) || wrLimit;
    syncExt = mode_reg[MD_SYNC] && mode_reg[MD_CLKSRC_LSB + 1];
  end

  // parity check of the incoming character
  always_comb
  begin
    logic parExp;
    parExp = ^(rxCharIn & charMask(mode_reg));
    parBad = 1'b0;
    if (mode_reg[MD_PAR_LSB + 1 +: 2] == PAR_MULTI_HI)
      parBad = rxParityBit;
    else if (mode_reg[MD_PAR_LSB + 1 +: 2] != PAR_NONE_HI)
    begin
      case (mode_reg[MD_PAR_LSB +: 3])
        PAR_EVEN: parBad = rxParityBit != parExp;
        PAR_ODD: parBad = rxParityBit == parExp;
        PAR_SPACE: parBad = rxParityBit;
        PAR_MARK: parBad = !rxParityBit;
        default: parBad = 1'b0;
      endcase
    end
  end

  // status word as software sees it
  always_comb
  begin
    txFreeBit = txOn_reg && !holdFull_reg && !brkPend_reg;
    drainedBit = txOn_reg && !holdFull_reg && !txShiftBusy && !brkPend_reg && !txBreakActive;
    statusWord = '0;
    statusWord[ST_RX_READY] = rxReady_reg;
    statusWord[ST_TX_FREE] = txFreeBit;
    statusWord[ST_BREAK] = breakSeen_reg;
    statusWord[ST_RX_DONE] = rxEndXfer;
    statusWord[ST_TX_DONE] = txEndXfer;
    statusWord[ST_OVERRUN] = overrun_reg;
    statusWord[ST_FRAMING] = framing_reg;
    statusWord[ST_PARITY] = parErr_reg;
    statusWord[ST_TIMEOUT] = timeout_reg;
    statusWord[ST_DRAINED] = drainedBit;
  end

  // registers, flags and read data; every hardware set beats a clear
  always_comb
  begin
    rxOn_next = rxOn_reg;
    txOn_next = txOn_reg;
    mode_next = mode_reg;
    mask_next = mask_reg;
    div_next = div_reg;
    limit_next = limit_reg;
    rxChar_next = rxChar_reg;
    txChar_next = txChar_reg;
    holdFull_next = holdFull_reg;
    brkPend_next = brkPend_reg;
    rdData_next = '0;
    if (wrCmd)
    begin
      if (regWrData[CMD_RX_ON]) rxOn_next = 1'b1;
      if (regWrData[CMD_RX_OFF]) rxOn_next = 1'b0;
      if (regWrData[CMD_TX_ON]) txOn_next = 1'b1;
      if (regWrData[CMD_TX_OFF]) txOn_next = 1'b0;
      if (regWrData[CMD_BREAK_START] && txOn_reg) brkPend_next = 1'b1;
    end
    if (regWr && hit(regAddr, OFS_MODE)) mode_next = regWrData[MD_WIDTH-1:0];
    if (regWr && hit(regAddr, OFS_IRQ_ENABLE)) mask_next = mask_reg | regWrData[ST_WIDTH-1:0];
    if (regWr && hit(regAddr, OFS_IRQ_DISABLE)) mask_next = mask_reg & ~regWrData[ST_WIDTH-1:0];
    if (regWr && hit(regAddr, OFS_BAUD)) div_next = regWrData[DIV_W-1:0];
    if (wrLimit) limit_next = regWrData[LIMIT_W-1:0];
    // handover to the shifter frees the holding register
    if (txShiftTake) holdFull_next = 1'b0;
    // a fresh break request in the take cycle must not be lost
    if (txBreakTake && !(wrCmd && regWrData[CMD_BREAK_START])) brkPend_next = 1'b0;
    if (regWr && hit(regAddr, OFS_TX_HOLDING))
    begin
      txChar_next = regWrData[CHAR_W-1:0] & charMask(mode_reg);
      holdFull_next = 1'b1;
    end
    // a disabled transmitter drops what waits
    if (!txOn_next)
    begin
      holdFull_next = 1'b0;
      brkPend_next = 1'b0;
    end
    if (rxCharDone && rxOn_reg) rxChar_next = rxCharIn & charMask(mode_reg);
    if (regRd)
    begin
      case (regAddr)
        OFS_MODE: rdData_next = 32'(mode_reg);
        OFS_IRQ_MASK: rdData_next = 32'(mask_reg);
        OFS_STATUS: rdData_next = 32'(statusWord);
        OFS_RX_HOLDING: rdData_next = 32'(rxChar_reg);
        OFS_BAUD: rdData_next = 32'(div_reg);
        OFS_IDLE_LIMIT: rdData_next = 32'(limit_reg);
        default: rdData_next = '0;
      endcase
    end
    rxReady_next = (rxCharDone && rxOn_reg) || (rxReady_reg && !rdRx && rxOn_next);
    overrun_next = (rxCharDone && rxOn_reg && rxReady_reg) || (overrun_reg && !rstStatus);
    breakSeen_next = rxBreakEvt || (breakSeen_reg && !rstStatus);
    framing_next = (rxCharDone && rxStopLow) || (framing_reg && !rstStatus);
    parErr_next = (rxCharDone && parBad) || (parErr_reg && !rstStatus);
    timeout_next = toExpire || (timeout_reg && !startTo);
    irq_next = |(statusWord & mask_reg);
  end

  // baud divider: sample tick is the 16x clock in async, the bit clock in sync
  always_comb
  begin
    logic srcTick, divTick;
    srcTick = (mode_reg[MD_CLKSRC_LSB +: 2] == CLKSRC_MASTER) ? 1'b1 : extClkEn;
    divTick = 1'b0;
    divCnt_next = divCnt_reg;
    subCnt_next = subCnt_reg;
    sample_next = 1'b0;
    bit_next = 1'b0;
    if (div_reg == DIV_BYPASS)
      divTick = srcTick;
    else if (div_reg != DIV_STOP && srcTick)
    begin
      if (divCnt_reg >= div_reg - DIV_BYPASS)
      begin
        divCnt_next = '0;
        divTick = 1'b1;
      end
      else
        divCnt_next = divCnt_reg + DIV_BYPASS;
    end
    if (syncExt)
    begin
      sample_next = extClkEn;
      bit_next = extClkEn;
    end
    else if (mode_reg[MD_SYNC])
    begin
      sample_next = divTick;
      bit_next = divTick;
    end
    else if (divTick)
    begin
      sample_next = 1'b1;
      subCnt_next = subCnt_reg + 4'h1;
      bit_next = subCnt_reg == OVERSAMPLE_LAST;
    end
  end

  // time-out sequencer: armed by start, counts once characters flow
  always_comb
  begin
    toState_next = toState_reg;
    toCnt_next = toCnt_reg;
    quarter_next = quarter_reg;
    toExpire = 1'b0;
    case (toState_reg)
      TO_IDLE: ;
      TO_ARMED:
        if (rxCharDone)
        begin
          toState_next = TO_RUN;
          toCnt_next = limit_reg;
          quarter_next = '0;
        end
      TO_RUN:
        // reload per char, four bits per step
        if (rxCharDone)
        begin
          toCnt_next = limit_reg;
          quarter_next = '0;
        end
        else if (bit_reg)
        begin
          quarter_next = quarter_reg + 2'h1;
          if (quarter_reg == QUARTER_LAST)
          begin
            if (toCnt_reg <= LIMIT_W'(1))
            begin
              toExpire = 1'b1;
              toState_next = TO_IDLE;
            end
            else
              toCnt_next = toCnt_reg - LIMIT_W'(1);
          end
        end
      default: toState_next = TO_IDLE;
    endcase
    if (startTo)
    begin
      toCnt_next = wrLimit ? regWrData[LIMIT_W-1:0] : limit_reg;
      quarter_next = '0;
      toState_next = (toCnt_next == LIMIT_RESET) ? TO_IDLE : TO_ARMED;
    end
  end

  // all state registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdData_reg <= '0;
      rxOn_reg <= 1'b0;
      txOn_reg <= 1'b0;
      mode_reg <= MODE_RESET;
      mask_reg <= MASK_RESET;
      div_reg <= DIV_RESET;
      limit_reg <= LIMIT_RESET;
      rxChar_reg <= '0;
      txChar_reg <= '0;
      holdFull_reg <= 1'b0;
      brkPend_reg <= 1'b0;
      rxReady_reg <= 1'b0;
      breakSeen_reg <= 1'b0;
      overrun_reg <= 1'b0;
      framing_reg <= 1'b0;
      parErr_reg <= 1'b0;
      timeout_reg <= 1'b0;
      irq_reg <= 1'b0;
      divCnt_reg <= '0;
      subCnt_reg <= '0;
      sample_reg <= 1'b0;
      bit_reg <= 1'b0;
      toState_reg <= TO_IDLE;
      toCnt_reg <= LIMIT_RESET;
      quarter_reg <= '0;
    end
    else
    begin
      rdData_reg <= rdData_next;
      rxOn_reg <= rxOn_next;
      txOn_reg <= txOn_next;
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      div_reg <= div_next;
      limit_reg <= limit_next;
      rxChar_reg <= rxChar_next;
      txChar_reg <= txChar_next;
      holdFull_reg <= holdFull_next;
      brkPend_reg <= brkPend_next;
      rxReady_reg <= rxReady_next;
      breakSeen_reg <= breakSeen_next;
      overrun_reg <= overrun_next;
      framing_reg <= framing_next;
      parErr_reg <= parErr_next;
      timeout_reg <= timeout_next;
      irq_reg <= irq_next;
      divCnt_reg <= divCnt_next;
      subCnt_reg <= subCnt_next;
      sample_reg <= sample_next;
      bit_reg <= bit_next;
      toState_reg <= toState_next;
      toCnt_reg <= toCnt_next;
      quarter_reg <= quarter_next;
    end
  end

  // outputs straight from flops
  assign regRdData = rdData_reg;
  assign txHoldValid = holdFull_reg;
  assign txHoldChar = txChar_reg;
  assign txBreakPending = brkPend_reg;
  assign sampleTick = sample_reg;
  assign bitTick = bit_reg;
  assign rxOn = rxOn_reg;
  assign txOn = txOn_reg;
  assign modeBits = mode_reg;
  assign chanIrq = irq_reg;

  property p_rx_ready_set;
    @(posedge clk) disable iff (sys_rst)
    rxCharDone && rxOn_reg |=> rxReady_reg ##1 (rxReady_reg || $past(rdRx) || !rxOn_reg);
  endproperty
  a_rx_ready_set: assert property (p_rx_ready_set) else $error("ready not set");

  property p_overrun;
    @(posedge clk) disable iff (sys_rst)
    rxCharDone && rxOn_reg && rxReady_reg && !rstStatus |=> overrun_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_framing_hold;
    @(posedge clk) disable iff (sys_rst)
    framing_reg && !rstStatus |=> framing_reg;
  endproperty
  a_framing_hold: assert property (p_framing_hold) else $error("framing lost");

  property p_break_seen;
    @(posedge clk) disable iff (sys_rst)
    rxBreakEvt |=> breakSeen_reg;
  endproperty
  a_break_seen: assert property (p_break_seen) else $error("break missed");

  property p_tx_off;
    @(posedge clk) disable iff (sys_rst)
    wrCmd && regWrData[CMD_TX_OFF] |=> !txFreeBit && !drainedBit;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx flags while off");

  property p_drained;
    @(posedge clk) disable iff (sys_rst)
    txShiftBusy || holdFull_reg || txBreakActive |-> !drainedBit;
  endproperty
  a_drained: assert property (p_drained) else $error("drained too early");

  property p_zero_limit;
    @(posedge clk) disable iff (sys_rst)
    limit_reg == LIMIT_RESET && !timeout_reg |=> !timeout_reg;
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("timeout at zero");

  property p_div_stop;
    @(posedge clk) disable iff (sys_rst)
    div_reg == DIV_STOP && !syncExt && $stable(div_reg) |=> !sample_reg;
  endproperty
  a_div_stop: assert property (p_div_stop) else $error("tick with zero divisor");

  property p_irq_enable;
    @(posedge clk) disable iff (sys_rst)
    regWr && hit(regAddr, OFS_IRQ_ENABLE) && regWrData[ST_RX_READY] |=> mask_reg[ST_RX_READY];
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("enable ignored");

endmodule : usbt_status_core

// ==== usbt_far_model.sv ====
`timescale 1ns/1ps
module usbt_far_model
  import usbt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bench requests
  input wire logic sendGo,
  input wire logic [CHAR_W-1:0] sendChar,
  input wire logic sendStopLow,
  input wire logic sendPar,
  input wire logic sendBrk,
  input wire logic [3:0] lag,
  // receiver side
  output logic rxCharDone,
  output logic [CHAR_W-1:0] rxCharIn,
  output logic rxStopLow,
  output logic rxParityBit,
  output logic rxBreakEvt,
  // transmitter side
  input wire logic txHoldValid,
  input wire logic txBreakPending,
  output logic txShiftTake,
  output logic txShiftBusy,
  output logic txBreakTake,
  output logic txBreakActive
);
  int busyCnt;
  int waitCnt;
  // receiver: fields only valid with the pulse, inverted every cycle after so stale data matches only every other cycle
  always @(posedge clk)
  begin
    rxCharDone <= sendGo && !sys_rst;
    rxBreakEvt <= sendBrk && !sys_rst;
    rxCharIn <= sys_rst ? 9'h000 : (sendGo ? sendChar : ~rxCharIn);
    rxStopLow <= sys_rst ? 1'b0 : (sendGo ? sendStopLow : ~rxStopLow);
    rxParityBit <= sys_rst ? 1'b0 : (sendGo ? sendPar : ~rxParityBit);
  end
  // shifter: takes a pending break first, else the held char, after lag idle cycles
  // busy covers the char, break active covers the break
  always @(posedge clk)
  begin
    txShiftTake <= 1'b0;
    txBreakTake <= 1'b0;
    if (sys_rst)
    begin
      busyCnt <= 0;
      waitCnt <= 0;
      txShiftBusy <= 1'b0;
      txBreakActive <= 1'b0;
    end
    else if (busyCnt > 0)
    begin
      busyCnt <= busyCnt - 1;
      txShiftBusy <= busyCnt > 1 && txShiftBusy;
      txBreakActive <= busyCnt > 1 && txBreakActive;
    end
    else if ((txHoldValid || txBreakPending) && waitCnt >= int'(lag))
    begin
      waitCnt <= 0;
      busyCnt <= 24;
      txBreakTake <= txBreakPending;
      txBreakActive <= txBreakPending;
      txShiftTake <= !txBreakPending;
      txShiftBusy <= !txBreakPending;
    end
    else
      waitCnt <= (txHoldValid || txBreakPending) ? waitCnt + 1 : 0;
  end
endmodule : usbt_far_model

// ==== uart_status_data_baud_timeout_tb.sv ====
`timescale 1ns/1ps
module uart_status_data_baud_timeout_tb
  import usbt_pkg::*;
;
  logic clk, sys_rst, regWr, regRd, rxEndXfer, txEndXfer, extClkEn;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic rxCharDone, rxStopLow, rxParityBit, rxBreakEvt, txShiftTake, txShiftBusy;
  logic txBreakTake, txBreakActive, txHoldValid, txBreakPending;
  logic sampleTick, bitTick, rxOn, txOn, chanIrq, sendGo, sendStopLow, sendPar, sendBrk;
  logic [CHAR_W-1:0] rxCharIn, txHoldChar, sendChar;
  logic [MD_WIDTH-1:0] modeBits;
  logic [3:0] lag;
  logic [31:0] expQ[$];
  logic rdSeen;
  int n_mismatch, n_compared, extPer, extCnt, g;
  logic [8:0] ch [4];
  usbt_status_core u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .rxCharDone(rxCharDone), .rxCharIn(rxCharIn), .rxStopLow(rxStopLow),
    .rxParityBit(rxParityBit), .rxBreakEvt(rxBreakEvt), .txShiftTake(txShiftTake),
    .txShiftBusy(txShiftBusy), .txBreakTake(txBreakTake), .txBreakActive(txBreakActive),
    .txHoldValid(txHoldValid), .txHoldChar(txHoldChar), .txBreakPending(txBreakPending),
    .rxEndXfer(rxEndXfer), .txEndXfer(txEndXfer), .extClkEn(extClkEn),
    .sampleTick(sampleTick), .bitTick(bitTick), .rxOn(rxOn), .txOn(txOn),
    .modeBits(modeBits), .chanIrq(chanIrq));
  usbt_far_model u_far (.clk(clk), .sys_rst(sys_rst), .sendGo(sendGo), .sendChar(sendChar),
    .sendStopLow(sendStopLow), .sendPar(sendPar), .sendBrk(sendBrk), .lag(lag),
    .rxCharDone(rxCharDone), .rxCharIn(rxCharIn), .rxStopLow(rxStopLow),
    .rxParityBit(rxParityBit), .rxBreakEvt(rxBreakEvt), .txHoldValid(txHoldValid),
    .txBreakPending(txBreakPending), .txShiftTake(txShiftTake), .txShiftBusy(txShiftBusy),
    .txBreakTake(txBreakTake), .txBreakActive(txBreakActive));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // external clock source, period extPer cycles, off at zero
  always @(posedge clk)
  begin
    extCnt <= (extCnt + 1 >= extPer) ? 0 : extCnt + 1;
    extClkEn <= extPer != 0 && extCnt == 0;
  end
  task results;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read data stands only in the cycle after the strobe: take the oldest note then
  always @(posedge clk)
  begin
    if (rdSeen)
    begin
      if (expQ.size() == 0)
        chk(regRdData, 32'hDEAD_0000);
      else
        chk(regRdData, expQ.pop_front());
    end
    rdSeen <= regRd;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd
  task send(input logic [8:0] c, input logic stopLow, input logic par, input logic brk);
    @(posedge clk);
    sendGo <= !brk;
    sendBrk <= brk;
    sendChar <= c;
    sendStopLow <= stopLow;
    sendPar <= par;
    @(posedge clk);
    sendGo <= 1'b0;
    sendBrk <= 1'b0;
  endtask : send
  // bounded wait for the shifter to drain char and break
  task idle;
    for (g = 0; g < 300 && (txHoldValid || txShiftBusy || txBreakPending || txBreakActive); g++)
      @(posedge clk);
    if (g == 300)
    begin
      chk(1'b0, 1'b1);
      results();
    end
    else
      cyc(2);
  endtask : idle
  // cycles between two pulses of a tick, zero if none within the bound
  task gap(input logic useBit, input int exp);
    int n;
    n = 0;
    for (g = 0; g < 300 && (useBit ? bitTick : sampleTick) !== 1'b1; g++)
      @(negedge clk);
    if (g < 300)
    begin
      @(negedge clk);
      for (n = 1; n < 300 && (useBit ? bitTick : sampleTick) !== 1'b1; n++)
        @(negedge clk);
    end
    chk(n, exp);
  endtask : gap
  initial
  begin
    {regWr, regRd, regAddr, regWrData, sendGo, sendBrk, sendChar, sendStopLow} = '0;
    {sendPar, extPer, n_mismatch, n_compared} = '0;
    {sys_rst, rxEndXfer, txEndXfer} = 3'b111;
    void'($urandom(98));
    lag = 4'h4 + 4'($urandom % 8);
    foreach (ch[i]) ch[i] = 9'($urandom);
    cyc(10);
    sys_rst <= 1'b0;
    rd(OFS_STATUS, 32'h18);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_RX_HOLDING, 32'h0);
    rd(8'h40, 32'h0);
    rd(OFS_TX_HOLDING, 32'h0);
    rxEndXfer <= 1'b0;
    rd(OFS_STATUS, 32'h10);
    {rxEndXfer, txEndXfer} <= 2'b10;
    rd(OFS_STATUS, 32'h08);
    {rxEndXfer, txEndXfer} <= 2'b00;
    wr(OFS_MODE, 32'h200C0);
    rd(OFS_MODE, 32'h200C0);
    chk(modeBits, 32'h200C0);
    wr(OFS_COMMAND, 32'h50);
    rd(OFS_STATUS, 32'h202);
    chk({rxOn, txOn}, 2'b11);
    wr(OFS_TX_HOLDING, 32'hFFFF_F1A5);
    rd(OFS_STATUS, 32'h000);
    chk(txHoldChar, 32'h1A5);
    chk(txHoldValid, 1'b1);
    idle();
    rd(OFS_STATUS, 32'h202);
    wr(OFS_COMMAND, 32'h200);
    rd(OFS_STATUS, 32'h000);
    chk(txBreakPending, 1'b1);
    idle();
    rd(OFS_STATUS, 32'h202);
    send(ch[0], 1'b0, ^ch[0], 1'b0);
    rd(OFS_STATUS, 32'h203);
    rd(OFS_RX_HOLDING, ch[0]);
    rd(OFS_STATUS, 32'h202);
    send(ch[1], 1'b0, ^ch[1], 1'b0);
    send(ch[2], 1'b0, ^ch[2], 1'b0);
    rd(OFS_STATUS, 32'h223);
    rd(OFS_RX_HOLDING, ch[2]);
    send(ch[3], 1'b1, ^ch[3], 1'b0);
    rd(OFS_STATUS, 32'h263);
    send(ch[1], 1'b0, ~^ch[1], 1'b0);
    rd(OFS_STATUS, 32'h2E3);
    send(9'h000, 1'b0, 1'b0, 1'b1);
    rd(OFS_STATUS, 32'h2E7);
    wr(OFS_COMMAND, 32'h100);
    rd(OFS_STATUS, 32'h203);
    rd(OFS_RX_HOLDING, ch[1]);
    wr(OFS_MODE, 32'h20CC0);
    send(ch[2], 1'b0, 1'b1, 1'b0);
    rd(OFS_STATUS, 32'h283);
    wr(OFS_COMMAND, 32'h100);
    rd(OFS_RX_HOLDING, ch[2]);
    send(ch[0], 1'b0, 1'b0, 1'b0);
    rd(OFS_STATUS, 32'h203);
    rd(OFS_RX_HOLDING, ch[0]);
    wr(OFS_IRQ_ENABLE, 32'h3FF);
    rd(OFS_IRQ_MASK, 32'h3FF);
    cyc(3);
    chk(chanIrq, 1'b1);
    wr(OFS_IRQ_DISABLE, 32'h3FE);
    wr(OFS_IRQ_ENABLE, 32'h0);
    rd(OFS_IRQ_MASK, 32'h001);
    cyc(3);
    chk(chanIrq, 1'b0);
    send(ch[3], 1'b0, 1'b0, 1'b0);
    cyc(3);
    chk(chanIrq, 1'b1);
    wr(OFS_IRQ_DISABLE, 32'h0);
    rd(OFS_RX_HOLDING, ch[3]);
    cyc(3);
    chk(chanIrq, 1'b0);
    // seven bits, odd parity: upper bits cut on both paths
    wr(OFS_MODE, 32'h280);
    wr(OFS_TX_HOLDING, 32'h1FF);
    send(ch[3], 1'b0, ~^(ch[3] & 9'h07F), 1'b0);
    chk(modeBits, 32'h280);
    chk(txHoldChar, 32'h07F);
    rd(OFS_STATUS, 32'h001);
    rd(OFS_RX_HOLDING, 32'(ch[3] & 9'h07F));
    idle();
    // divisor sweep: async, stop, sync even, external sync, bypass
    wr(OFS_MODE, 32'h200C0);
    wr(OFS_BAUD, 32'h4);
    rd(OFS_BAUD, 32'h4);
    gap(1'b0, 4);
    gap(1'b1, 64);
    wr(OFS_BAUD, 32'h0);
    cyc(2);
    gap(1'b0, 0);
    wr(OFS_BAUD, 32'h6);
    wr(OFS_MODE, 32'h201C0);
    gap(1'b0, 6);
    extPer = 5;
    wr(OFS_MODE, 32'h201E0);
    gap(1'b0, 5);
    extPer = 3;
    wr(OFS_BAUD, 32'h1);
    wr(OFS_MODE, 32'h200D0);
    gap(1'b0, 3);
    gap(1'b1, 48);
    // idle limit 2 with bit period 32 cycles: expiry 256 cycles after a char
    wr(OFS_MODE, 32'h200C0);
    wr(OFS_BAUD, 32'h2);
    wr(OFS_IDLE_LIMIT, 32'h2);
    rd(OFS_IDLE_LIMIT, 32'h2);
    send(ch[0], 1'b0, ^ch[0], 1'b0);
    cyc(200);
    rd(OFS_STATUS, 32'h203);
    cyc(100);
    rd(OFS_STATUS, 32'h303);
    wr(OFS_COMMAND, 32'h800);
    rd(OFS_STATUS, 32'h203);
    rd(OFS_RX_HOLDING, ch[0]);
    send(ch[1], 1'b0, ^ch[1], 1'b0);
    cyc(300);
    rd(OFS_STATUS, 32'h303);
    wr(OFS_IDLE_LIMIT, 32'h0);
    rd(OFS_STATUS, 32'h203);
    rd(OFS_RX_HOLDING, ch[1]);
    send(ch[2], 1'b0, ^ch[2], 1'b0);
    cyc(400);
    rd(OFS_STATUS, 32'h203);
    // both directions off, then transmitter back on
    wr(OFS_COMMAND, 32'hA0);
    rd(OFS_STATUS, 32'h000);
    chk({rxOn, txOn}, 2'b00);
    wr(OFS_COMMAND, 32'h40);
    rd(OFS_STATUS, 32'h202);
    cyc(3);
    results();
  end
endmodule : uart_status_data_baud_timeout_tb
